// *** hdl/ldp_port.sv ***
// registered port between the processor bus and character display modules
//
// Operation
// R01 - a 16-bit latched register holds the display control lines and data byte.
// R02 - software runs each display access as three bus cycles for a write, four for a read.
// R03 - the first cycle writes command/data, direction and data with both selects at 0.
// R04 - the second cycle raises the wanted selects and rewrites the other fields unchanged.
// R05 - for a read, the third cycle reads the register to fetch the byte from the module.
// R06 - a write sequence ends with a third cycle writing both selects idle.
// R07 - a read sequence ends with a fourth cycle writing both selects idle.
// R08 - bit 0 drives the first display select, 1 meaning active.
// R09 - bit 1 drives the second display select, 1 meaning active.
// R10 - bit 6 drives command/data select, 0 command and 1 display data.
// R11 - bit 7 drives direction, 0 write to module and 1 read from module.
// R12 - bits 8 to 15 carry the data byte reversed, driven on write and sampled on read.
// R13 - the port answers only when its enable switch is on, at offset 0x0010 in its chip select.
// R14 - bits 2 to 5 ignore writes and read as zero.
// R15 - reset clears the register, deselecting modules and releasing the data lines.
`timescale 1ns/1ps
`default_nettype none

module ldp_port (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic port_chip_select_n_i,
  input wire logic port_enable_sw_i,
  input wire logic [ldp_pkg::LDP_ADDR_W-1:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [ldp_pkg::LDP_REG_W-1:0] bus_wdata_i,
  output logic [ldp_pkg::LDP_REG_W-1:0] bus_rdata_o,
  output logic bus_ack_o,
  output logic first_display_select_o,
  output logic second_display_select_o,
  output logic cmd_data_select_o,
  output logic read_not_write_o,
  input wire logic [ldp_pkg::LDP_DATA_W-1:0] disp_data_i,
  output logic [ldp_pkg::LDP_DATA_W-1:0] disp_data_o,
  output logic disp_data_oe_o
);
  import ldp_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [LDP_DATA_W-1:0] din_s1_q, din_s2_q;
  logic sw_s1_q, sw_s2_q;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      din_s1_q <= '0;
      din_s2_q <= '0;
      sw_s1_q <= 1'b0;
      sw_s2_q <= 1'b0;
    end else begin
      din_s1_q <= disp_data_i;
      din_s2_q <= din_s1_q;
      sw_s1_q <= port_enable_sw_i;
      sw_s2_q <= sw_s1_q;
    end
  end

  // ************************************************************
  // decode and register
  // ************************************************************
  logic hit;
  logic [LDP_REG_W-1:0] reg_q, reg_d;
  logic [LDP_REG_W-1:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic oe_q, oe_d;
  logic [LDP_DATA_W-1:0] rev_in;
  logic [LDP_DATA_W-1:0] dout;

  assign hit = !port_chip_select_n_i && sw_s2_q && (bus_addr_i == LDP_REG_OFFSET); // R13

  // module bit 7 sits on register bit 8, both ways
  genvar gi;
  for (gi = 0; gi < LDP_DATA_W; gi++) begin : g_rev
    assign rev_in[gi] = din_s2_q[LDP_DATA_W-1-gi]; // R12
    assign dout[LDP_DATA_W-1-gi] = reg_q[LDP_DATA_LO+gi]; // R12
  end

  always_comb begin
    reg_d = reg_q;
    rdata_d = rdata_q;
    ack_d = 1'b0;
    oe_d = oe_q;
    if (hit && bus_wr_i) begin
      reg_d = bus_wdata_i & LDP_WR_MASK; // R01 R03 R04 R06 R07 R14
      oe_d = !bus_wdata_i[LDP_BIT_RW]; // R12
      ack_d = 1'b1;
    end else if (hit && bus_rd_i) begin
      rdata_d = reg_q; // R05
      if (reg_q[LDP_BIT_RW]) begin
        rdata_d[LDP_DATA_LO +: LDP_DATA_W] = rev_in; // R12
      end
      ack_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_q <= LDP_REG_RESET; // R15
      rdata_q <= '0;
      ack_q <= 1'b0;
      oe_q <= 1'b0; // R15
    end else begin
      reg_q <= reg_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign bus_rdata_o = rdata_q;
  assign bus_ack_o = ack_q;
  assign first_display_select_o = reg_q[LDP_BIT_SEL1]; // R08
  assign second_display_select_o = reg_q[LDP_BIT_SEL2]; // R09
  assign cmd_data_select_o = reg_q[LDP_BIT_CMD_DATA]; // R10
  assign read_not_write_o = reg_q[LDP_BIT_RW]; // R11
  assign disp_data_o = dout;
  assign disp_data_oe_o = oe_q; // R12 R15

  // ************************************************************
  // checks
  // ************************************************************
  sequence wr_hit_s;
    hit && bus_wr_i;
  endsequence

  sequence rd_hit_s;
    hit && bus_rd_i && !bus_wr_i;
  endsequence

  // read while the port listens to the module
  sequence rd_pin_s;
    rd_hit_s ##0 reg_q[LDP_BIT_RW];
  endsequence

  // read while the port drives the module
  sequence rd_reg_s;
    rd_hit_s ##0 !reg_q[LDP_BIT_RW];
  endsequence

  reg_store_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R01
    wr_hit_s |=> reg_q == ($past(bus_wdata_i) & LDP_WR_MASK))
    else $error("register did not latch write");
  reserved_zero_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R14
    reg_q[5:2] == 4'h0)
    else $error("reserved bits not zero");
  sel_one_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R08
    wr_hit_s |=> first_display_select_o == $past(bus_wdata_i[LDP_BIT_SEL1]))
    else $error("first select mismatch");
  sel_two_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R09
    wr_hit_s |=> second_display_select_o == $past(bus_wdata_i[1]))
    else $error("second select mismatch");
  cmd_data_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R10
    wr_hit_s |=> cmd_data_select_o == $past(bus_wdata_i[6]))
    else $error("command data select mismatch");
  dir_oe_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R12
    wr_hit_s |=> disp_data_oe_o == !$past(bus_wdata_i[LDP_BIT_RW]))
    else $error("direction and enable disagree");
  data_rev_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R12
    wr_hit_s |=> disp_data_o[LDP_DATA_W-1] == $past(bus_wdata_i[LDP_DATA_LO]) &&
      disp_data_o[0] == $past(bus_wdata_i[LDP_REG_W-1]))
    else $error("data byte not reversed");
  no_hit_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R13
    !hit |=> !bus_ack_o && $stable(reg_q))
    else $error("answered without decode");

  sw_off_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R13
    !sw_s2_q |=> !bus_ack_o)
    else $error("answered with the port switched off");

  dir_write_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R11
    wr_hit_s |=> read_not_write_o == $past(bus_wdata_i[LDP_BIT_RW]))
    else $error("direction select mismatch");

  bus_fight_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R12
    !(disp_data_oe_o && read_not_write_o))
    else $error("data lines driven during a module read");

  reset_idle_a: assert property (@(posedge mclk_i) // R15
    !arst_n_i |-> !first_display_select_o && !second_display_select_o && !disp_data_oe_o)
    else $error("reset left a select or the data drive on");

  reg_hold_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R01
    !(hit && bus_wr_i) |=> $stable(reg_q) && $stable(disp_data_oe_o))
    else $error("register changed without a write");

  // ************************************************************
  // acknowledge and read path checks
  // ************************************************************
  ack_pulse_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R13
    hit && (bus_wr_i || bus_rd_i) |=> bus_ack_o)
    else $error("decoded access not acknowledged");

  read_back_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R01
    rd_reg_s |=> bus_rdata_o == $past(reg_q))
    else $error("read did not return the register");

  read_byte_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R12
    rd_pin_s |=> bus_rdata_o[LDP_DATA_LO] == $past(din_s2_q[LDP_DATA_W-1]) &&
      bus_rdata_o[LDP_REG_W-1] == $past(din_s2_q[0]))
    else $error("module byte not reversed on read");

  read_zero_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R14
    rd_hit_s |=> (bus_rdata_o & ~LDP_WR_MASK) == '0)
    else $error("reserved bits not zero on read");

  rdata_hold_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R01
    !(hit && bus_rd_i && !bus_wr_i) |=> $stable(bus_rdata_o))
    else $error("read data changed without a read");
endmodule

`default_nettype wire

// *** hdl/ldp_pkg.sv ***
// constants for the display access register port
package ldp_pkg;
  localparam int unsigned LDP_REG_W = 16;
  localparam int unsigned LDP_ADDR_W = 16;
  localparam logic [15:0] LDP_REG_OFFSET = 16'h0010;
  localparam int unsigned LDP_BIT_SEL1 = 0;
  localparam int unsigned LDP_BIT_SEL2 = 1;
  localparam int unsigned LDP_BIT_CMD_DATA = 6;
  localparam int unsigned LDP_BIT_RW = 7;
  localparam int unsigned LDP_DATA_LO = 8;
  localparam int unsigned LDP_DATA_W = 8;
  localparam logic [15:0] LDP_REG_RESET = 16'h0000;
  localparam logic [15:0] LDP_WR_MASK = 16'hffc3;
endpackage

// *** tb/ldp_disp_model.sv ***
// character display module model for the port bench
`timescale 1ns/1ps
`default_nettype none
module ldp_disp_model #(parameter logic [7:0] RESP = 8'h1e) (
  input wire logic mclk_i,
  input wire logic sel_i,
  input wire logic rnw_i,
  output logic [7:0] data_o
);
  initial data_o = 8'h00;
  // answers only while selected for a read, otherwise the lines churn
  always @(posedge mclk_i) data_o <= (sel_i && rnw_i) ? RESP : ~data_o;
endmodule
`default_nettype wire

// *** tb/ldp_port_bench.sv ***
// self-checking bench for the display access register port
`timescale 1ns/1ps
`default_nettype none
module ldp_port_bench;
  import ldp_pkg::*;
  logic mclk_i = 1'b0, arst_n_i = 1'b1, cs_n = 1'b1, sw = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000;
  wire logic [15:0] rdata;
  wire logic [7:0] dout, din;
  wire logic ack, s1, s2, cd, rnw, oe;
  int failures = 0, total_checks = 0;
  initial forever #50 mclk_i = ~mclk_i;
  ldp_port dut_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .port_chip_select_n_i(cs_n),
    .port_enable_sw_i(sw), .bus_addr_i(addr), .bus_wr_i(wr), .bus_rd_i(rd),
    .bus_wdata_i(wdata), .bus_rdata_o(rdata), .bus_ack_o(ack), .first_display_select_o(s1),
    .second_display_select_o(s2), .cmd_data_select_o(cd), .read_not_write_o(rnw),
    .disp_data_i(din), .disp_data_o(dout), .disp_data_oe_o(oe));
  ldp_disp_model disp_u (.mclk_i(mclk_i), .sel_i(s1 | s2), .rnw_i(rnw), .data_o(din));
  function automatic logic [7:0] rev(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev[i] = b[7-i];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus cycle; the answer lands on the same edge that takes the strobe
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic hit);
    @(posedge mclk_i);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge mclk_i);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 chk({15'h0000, ack}, {15'h0000, hit});
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    arst_n_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    chk({oe, s2, s1, cd, rnw, 3'h0, dout}, 16'h0000);
    $display("reset test done");
    arst_n_i <= 1'b1;
    cs_n <= 1'b0;
    sw <= 1'b1;
    repeat (3) @(posedge mclk_i);
    acc(1'b1, 16'h0010, 16'ha07c, 1'b1);
    chk({oe, s2, s1, cd, rnw, 3'h0, dout}, 16'h9005);
    acc(1'b1, 16'h0010, 16'ha07d, 1'b1);
    chk({oe, s2, s1, cd, rnw, 3'h0, dout}, 16'hb005);
    acc(1'b1, 16'h0010, 16'ha07c, 1'b1);
    chk({oe, s2, s1, cd, rnw, 3'h0, dout}, 16'h9005);
    acc(1'b0, 16'h0010, 16'h0000, 1'b1);
    chk(rdata, 16'ha040);
    $display("write sequence done");
    acc(1'b1, 16'h0010, 16'h33c0, 1'b1);
    chk({oe, s2, s1, cd, rnw, 11'h000}, 16'h1800);
    acc(1'b1, 16'h0010, 16'h33c2, 1'b1);
    chk({oe, s2, s1, cd, rnw, 11'h000}, 16'h5800);
    repeat (3) @(posedge mclk_i);
    acc(1'b0, 16'h0010, 16'h0000, 1'b1);
    chk(rdata, {rev(8'h1e), 8'hc2});
    acc(1'b1, 16'h0010, 16'h33c0, 1'b1);
    chk({oe, s2, s1, cd, rnw, 11'h000}, 16'h1800);
    $display("read sequence done");
    acc(1'b1, 16'h0010, 16'h5a01, 1'b1);
    chk({oe, s2, s1, cd, rnw, 3'h0, dout}, 16'ha05a);
    for (int i = 0; i < 3; i++) begin
      cs_n <= (i == 0);
      sw <= (i != 1);
      repeat (3) @(posedge mclk_i);
      acc(1'b1, (i == 2) ? 16'h0012 : 16'h0010, 16'hffff, 1'b0);
    end
    cs_n <= 1'b0;
    sw <= 1'b1;
    repeat (3) @(posedge mclk_i);
    acc(1'b0, 16'h0010, 16'h0000, 1'b1);
    chk(rdata, 16'h5a01);
    $display("refusal test done");
    final_report();
  end
  initial begin
    #50us;
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
